// [psio_field_model.sv]
// Switches, interrupt sources and loads wired to the controller terminals
`timescale 1ns/100ps
`default_nettype none
module psio_field_model (
   input  wire logic       clk,
   input  wire logic [7:0] swLevel,
   input  wire logic [2:0] irqChan,
   input  wire logic       irqFire,
   output logic      [7:0] physicalInputPin,
   output logic      [7:0] extInputIrq,
   input  wire logic [7:0] outputContact,
   output logic      [7:0] loadOn
);
   // Pin level and its interrupt launch on the same edge
   always_ff @(posedge clk) begin
      physicalInputPin <= swLevel;
      extInputIrq      <= irqFire ? (8'h01 << irqChan) : 8'h00;
   end

   always_ff @(posedge clk) begin
      loadOn <= outputContact;
   end
endmodule
`default_nettype wire

// [psio_map.svh]
// Register offsets, field positions, reset values and timing counts of the scan I/O image block
`ifndef PSIO_MAP_SVH
`define PSIO_MAP_SVH

`define PSIO_OFF_CTRL       8'h00
`define PSIO_OFF_STATUS     8'h04
`define PSIO_OFF_PROG_ADDR  8'h08
`define PSIO_OFF_PROG_DATA  8'h0C
`define PSIO_OFF_OUT_IMG    8'h10
`define PSIO_OFF_IN_IMG     8'h14
`define PSIO_OFF_SCAN_CNT   8'h18
`define PSIO_OFF_SPECIAL    8'h1C

`define PSIO_CTRL_RUN       0
`define PSIO_CTRL_CLR_BAD   1
`define PSIO_STAT_RUN       0
`define PSIO_STAT_INIT      1
`define PSIO_STAT_BAD       2
`define PSIO_STAT_ST_LSB    4
`define PSIO_STAT_ST_MSB    6

`define PSIO_OPC_MSB        31
`define PSIO_OPC_LSB        28
`define PSIO_TYP_MSB        25
`define PSIO_TYP_LSB        24
`define PSIO_D2_MSB         11
`define PSIO_D2_LSB         8
`define PSIO_D1_MSB         7
`define PSIO_D1_LSB         4
`define PSIO_D0_MSB         3
`define PSIO_D0_LSB         0

`define PSIO_M_CAPT         100
`define PSIO_M_INIT         108
`define PSIO_M_ERR          109
`define PSIO_M_REBOOT       110

`define PSIO_RUN_RST        1'h0
`define PSIO_PC_LAST        8'hFF
`define PSIO_INIT_CYCLES    16'h0010

`endif

// [psio_mem_if.sv]
// Interface between the scan engine and its program memory
`timescale 1ns/100ps
`default_nettype none
interface psio_mem_if;
   import psio_pkg::*;
   logic       wrEn;
   psio_pc_t   wrAddr;
   psio_word_t wrData;
   psio_pc_t   rdAddr;
   psio_word_t rdData;
   modport ctrl (output wrEn, output wrAddr, output wrData, output rdAddr, input rdData);
   modport mem  (input wrEn, input wrAddr, input wrData, input rdAddr, output rdData);
endinterface
`default_nettype wire

// [psio_pkg.sv]
// Types of the scan I/O image block
`default_nettype none
package psio_pkg;

   typedef enum logic [3:0] {
      OP_NOP = 4'h0,
      OP_LD  = 4'h1,
      OP_LDI = 4'h2,
      OP_AND = 4'h3,
      OP_ANI = 4'h4,
      OP_OR  = 4'h5,
      OP_ORI = 4'h6,
      OP_OUT = 4'h7,
      OP_SET = 4'h8,
      OP_RST = 4'h9,
      OP_END = 4'hF
   } psio_op_e;

   typedef enum logic [1:0] {
      OPD_X    = 2'h0,
      OPD_Y    = 2'h1,
      OPD_M    = 2'h2,
      OPD_NONE = 2'h3
   } psio_opd_e;

   typedef enum logic [2:0] {
      ST_IDLE   = 3'h0,
      ST_INIT   = 3'h1,
      ST_SAMPLE = 3'h2,
      ST_FETCH  = 3'h3,
      ST_EXEC   = 3'h4,
      ST_OUTPUT = 3'h5,
      ST_REBOOT = 3'h6
   } psio_state_e;

   typedef logic [7:0]  psio_pc_t;
   typedef logic [31:0] psio_word_t;

endpackage
`default_nettype wire

// [psio_prog_mem.sv]
// Program memory with registered read data
`timescale 1ns/100ps
`default_nettype none
module psio_prog_mem
   import psio_pkg::*;
(
   input wire logic clk,
   psio_mem_if.mem  port
);

   psio_word_t store [0:255];

   always_ff @(posedge clk) begin
      if (port.wrEn) begin
         store[port.wrAddr] <= port.wrData;
      end
   end

   always_ff @(posedge clk) begin
      port.rdData <= store[port.rdAddr];
   end

endmodule
`default_nettype wire

// [psio_scan_io.sv]
// Scan-cycle input/output image engine with special relays and APB register slave
//
// Contract
// - Every discrete input is sampled once at scan start and held as the input image for the whole scan.
// - A pulse shorter than one scan may be missed; only the level at the scan-start sample counts.
// - Each scan runs the program in order from line zero and keeps every operand result in operand memory.
// - The output image goes to the output latch only after the end instruction, or program line 255, has executed.
// - If a coil is written several times in a scan, the last write in program order decides.
// - Input and output operand addresses are octal, so digits eight and nine are invalid.
// - Servicing interrupt n loads capture relay n with the live level of physical input n.
// - The init-done relay rises when peripheral initialisation completes and then stays high until the program clears it or a reboot.
// - When the program clears the init-done relay, peripheral initialisation is run again.
// - Setting the error relay lights the front-panel error lamp and clearing it turns the lamp off.
// - With the reboot relay set, clearing init-done causes a complete reboot instead of a re-init.
// - General-purpose internal relays are not retained and start cleared after power-up.
// - Output image bits 0 to 7 drive the physical output contacts through the output latch.
`include "psio_map.svh"
`timescale 1ns/100ps
`default_nettype none
module psio_scan_io
   import psio_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [7:0]  physicalInputPin,
   input  wire logic [7:0]  extInputIrq,
   output logic      [7:0]  outputContact,
   output logic             errorLamp,
   output logic             initDoneFlag
);

   psio_state_e  state_ff;
   psio_state_e  nxt_state;
   psio_pc_t     pc_ff;
   psio_pc_t     progAddr_ff;
   logic [127:0] xImg_ff;
   logic [127:0] yImg_ff;
   logic [127:0] mImg_ff;
   logic [7:0]   outLatch_ff;
   logic         acc_ff;
   logic         run_ff;
   logic         badAddr_ff;
   logic         reinitReq_ff;
   logic         rebootReq_ff;
   logic         errLamp_ff;
   logic [15:0]  initCnt_ff;
   logic [31:0]  scanCnt_ff;
   logic         pready_ff;
   logic         pslverr_ff;
   logic [31:0]  prdata_ff;

   psio_op_e     opc;
   psio_opd_e    opdType;
   logic [3:0]   dig2;
   logic [3:0]   dig1;
   logic [3:0]   dig0;
   logic [10:0]  decSum;
   logic [6:0]   opdIdx;
   logic         opdOk;
   logic         opdVal;
   logic         execStep;
   logic         needOpd;
   logic         isWrite;
   logic         badOpd;
   logic         doWrite;
   logic         wrBit;
   logic         initDoneNow;
   logic         apbFirst;
   logic         apbDone;
   logic         regHit;
   logic [31:0]  readVal;

   psio_mem_if memBus ();

   psio_prog_mem uMem (
      .clk  (clk),
      .port (memBus)
   );

   assign memBus.rdAddr = pc_ff;
   assign memBus.wrAddr = progAddr_ff;
   assign memBus.wrData = pwdata;
   assign memBus.wrEn   = apbDone && pwrite && (paddr == `PSIO_OFF_PROG_DATA);

   // Instruction decode and operand fetch
   always_comb begin
      opc     = psio_op_e'(memBus.rdData[`PSIO_OPC_MSB:`PSIO_OPC_LSB]);
      opdType = psio_opd_e'(memBus.rdData[`PSIO_TYP_MSB:`PSIO_TYP_LSB]);
      dig2    = memBus.rdData[`PSIO_D2_MSB:`PSIO_D2_LSB];
      dig1    = memBus.rdData[`PSIO_D1_MSB:`PSIO_D1_LSB];
      dig0    = memBus.rdData[`PSIO_D0_MSB:`PSIO_D0_LSB];
      decSum  = 11'(dig2) * 11'h064 + 11'(dig1) * 11'h00A + 11'(dig0);
      opdIdx  = 7'h00;
      opdOk   = 1'b0;
      opdVal  = 1'b0;
      if (opdType == OPD_M) begin
         opdOk  = (dig2 <= 4'h9) && (dig1 <= 4'h9) && (dig0 <= 4'h9) && (decSum < 11'h080);
         opdIdx = decSum[6:0];
      end else if (opdType != OPD_NONE) begin
         opdOk  = (dig2 <= 4'h1) && (dig1 <= 4'h7) && (dig0 <= 4'h7);
         opdIdx = {dig2[0], dig1[2:0], dig0[2:0]};
      end
      if (opdType == OPD_X) begin
         opdVal = xImg_ff[opdIdx];
      end else if (opdType == OPD_Y) begin
         opdVal = yImg_ff[opdIdx];
      end else if (opdType == OPD_M) begin
         opdVal = mImg_ff[opdIdx];
      end
   end

   assign execStep    = (state_ff == ST_EXEC);
   assign needOpd     = (opc != OP_NOP) && (opc != OP_END);
   assign isWrite     = (opc == OP_OUT) || (opc == OP_SET) || (opc == OP_RST);
   assign badOpd      = execStep && needOpd && (!opdOk || (isWrite && (opdType == OPD_X)));
   assign doWrite     = execStep && isWrite && !badOpd && ((opc == OP_OUT) || acc_ff);
   assign wrBit       = (opc == OP_RST) ? 1'b0 : ((opc == OP_SET) ? 1'b1 : acc_ff);
   assign initDoneNow = (state_ff == ST_INIT) && (initCnt_ff == 16'h0000);

   // Scan sequencer
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         ST_IDLE: begin
            if (run_ff) begin
               nxt_state = mImg_ff[`PSIO_M_INIT] ? ST_SAMPLE : ST_INIT;
            end
         end
         ST_INIT: begin
            if (initDoneNow) begin
               nxt_state = ST_SAMPLE;
            end
         end
         ST_SAMPLE: begin
            nxt_state = ST_FETCH;
         end
         ST_FETCH: begin
            nxt_state = ST_EXEC;
         end
         ST_EXEC: begin
            if ((opc == OP_END) || (pc_ff == `PSIO_PC_LAST)) begin
               nxt_state = ST_OUTPUT;
            end else begin
               nxt_state = ST_FETCH;
            end
         end
         ST_OUTPUT: begin
            if (rebootReq_ff) begin
               nxt_state = ST_REBOOT;
            end else if (reinitReq_ff) begin
               nxt_state = ST_INIT;
            end else if (run_ff) begin
               nxt_state = ST_SAMPLE;
            end else begin
               nxt_state = ST_IDLE;
            end
         end
         ST_REBOOT: begin
            nxt_state = ST_INIT;
         end
         default: begin
            nxt_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_ff <= ST_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   always_ff @(posedge clk) begin
      if (rst || (state_ff != ST_INIT)) begin
         initCnt_ff <= `PSIO_INIT_CYCLES - 16'h0001;
      end else if (initCnt_ff != 16'h0000) begin
         initCnt_ff <= initCnt_ff - 16'h0001;
      end
   end

   always_ff @(posedge clk) begin
      if (rst || (state_ff == ST_SAMPLE)) begin
         pc_ff <= 8'h00;
      end else if (execStep && (nxt_state == ST_FETCH)) begin
         pc_ff <= pc_ff + 8'h01;
      end
   end

   always_ff @(posedge clk) begin
      if (rst || (state_ff == ST_SAMPLE)) begin
         acc_ff <= 1'b0;
      end else if (execStep && !badOpd) begin
         case (opc)
            OP_LD:   acc_ff <= opdVal;
            OP_LDI:  acc_ff <= ~opdVal;
            OP_AND:  acc_ff <= acc_ff & opdVal;
            OP_ANI:  acc_ff <= acc_ff & ~opdVal;
            OP_OR:   acc_ff <= acc_ff | opdVal;
            OP_ORI:  acc_ff <= acc_ff | ~opdVal;
            default: acc_ff <= acc_ff;
         endcase
      end
   end

   // Input image: taken only at scan start, never by interrupt servicing
   always_ff @(posedge clk) begin
      if (rst || (state_ff == ST_REBOOT)) begin
         xImg_ff <= '0;
      end else if (state_ff == ST_SAMPLE) begin
         xImg_ff[7:0] <= physicalInputPin;
      end
   end

   always_ff @(posedge clk) begin
      if (rst || (state_ff == ST_REBOOT)) begin
         yImg_ff <= '0;
      end else if (doWrite && (opdType == OPD_Y)) begin
         yImg_ff[opdIdx] <= wrBit;
      end
   end

   always_ff @(posedge clk) begin
      if (rst || (state_ff == ST_REBOOT)) begin
         outLatch_ff <= 8'h00;
      end else if (state_ff == ST_OUTPUT) begin
         outLatch_ff <= yImg_ff[7:0];
      end
   end

   // Internal relays; interrupt capture comes last so it wins a same-cycle program write
   always_ff @(posedge clk) begin
      if (rst || (state_ff == ST_REBOOT)) begin
         mImg_ff <= '0;
      end else begin
         if (doWrite && (opdType == OPD_M)) begin
            mImg_ff[opdIdx] <= wrBit;
         end
         if (initDoneNow) begin
            mImg_ff[`PSIO_M_INIT] <= 1'b1;
         end
         for (int n = 0; n < 8; n++) begin
            if (extInputIrq[n]) begin
               mImg_ff[`PSIO_M_CAPT + n] <= physicalInputPin[n];
            end
         end
      end
   end

   // A program clear of init-done asks for re-init or, with the reboot relay set, a reboot
   always_ff @(posedge clk) begin
      if (rst || (state_ff == ST_INIT) || (state_ff == ST_REBOOT)) begin
         reinitReq_ff <= 1'b0;
         rebootReq_ff <= 1'b0;
      end else if (doWrite && (opdType == OPD_M) && (opdIdx == 7'(`PSIO_M_INIT)) && !wrBit
                   && mImg_ff[`PSIO_M_INIT]) begin
         reinitReq_ff <= 1'b1;
         rebootReq_ff <= mImg_ff[`PSIO_M_REBOOT];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         errLamp_ff <= 1'b0;
      end else begin
         errLamp_ff <= mImg_ff[`PSIO_M_ERR];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         scanCnt_ff <= 32'h0000_0000;
      end else if (state_ff == ST_OUTPUT) begin
         scanCnt_ff <= scanCnt_ff + 32'h0000_0001;
      end
   end

   // APB slave: one wait state, writes take effect at the completing edge
   assign apbFirst = psel && penable && !pready_ff;
   assign apbDone  = psel && penable && pready_ff;

   always_comb begin
      regHit  = 1'b1;
      readVal = 32'h0000_0000;
      if (paddr == `PSIO_OFF_CTRL) begin
         readVal[`PSIO_CTRL_RUN] = run_ff;
      end else if (paddr == `PSIO_OFF_STATUS) begin
         readVal[`PSIO_STAT_RUN]  = (state_ff != ST_IDLE);
         readVal[`PSIO_STAT_INIT] = mImg_ff[`PSIO_M_INIT];
         readVal[`PSIO_STAT_BAD]  = badAddr_ff;
         readVal[`PSIO_STAT_ST_MSB:`PSIO_STAT_ST_LSB] = state_ff;
      end else if (paddr == `PSIO_OFF_PROG_ADDR) begin
         readVal[7:0] = progAddr_ff;
      end else if (paddr == `PSIO_OFF_PROG_DATA) begin
         readVal = 32'h0000_0000;
      end else if (paddr == `PSIO_OFF_OUT_IMG) begin
         readVal[7:0] = outLatch_ff;
      end else if (paddr == `PSIO_OFF_IN_IMG) begin
         readVal[7:0] = xImg_ff[7:0];
      end else if (paddr == `PSIO_OFF_SCAN_CNT) begin
         readVal = scanCnt_ff;
      end else if (paddr == `PSIO_OFF_SPECIAL) begin
         readVal[10:0] = mImg_ff[`PSIO_M_REBOOT:`PSIO_M_CAPT];
      end else begin
         regHit = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
      end else begin
         pready_ff  <= apbFirst;
         pslverr_ff <= apbFirst && !regHit;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         prdata_ff <= 32'h0000_0000;
      end else if (apbFirst && !pwrite) begin
         prdata_ff <= readVal;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         run_ff <= `PSIO_RUN_RST;
      end else if (apbDone && pwrite && (paddr == `PSIO_OFF_CTRL)) begin
         run_ff <= pwdata[`PSIO_CTRL_RUN];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         progAddr_ff <= 8'h00;
      end else if (apbDone && pwrite && (paddr == `PSIO_OFF_PROG_ADDR)) begin
         progAddr_ff <= pwdata[7:0];
      end else if (memBus.wrEn) begin
         progAddr_ff <= progAddr_ff + 8'h01;
      end
   end

   // Bad operand flag: a new fault beats a same-cycle software clear
   always_ff @(posedge clk) begin
      if (rst) begin
         badAddr_ff <= 1'b0;
      end else if (badOpd) begin
         badAddr_ff <= 1'b1;
      end else if (apbDone && pwrite && (paddr == `PSIO_OFF_CTRL) && pwdata[`PSIO_CTRL_CLR_BAD]) begin
         badAddr_ff <= 1'b0;
      end
   end

   assign prdata        = prdata_ff;
   assign pready        = pready_ff;
   assign pslverr       = pslverr_ff;
   assign outputContact = outLatch_ff;
   assign errorLamp     = errLamp_ff;
   assign initDoneFlag  = mImg_ff[`PSIO_M_INIT];

endmodule
`default_nettype wire

// [psio_scan_io_properties.sv]
// Port-level assertions for the scan I/O image engine
`timescale 1ns/100ps
`default_nettype none
module psio_scan_io_properties (
   input wire logic       clk,
   input wire logic       rst,
   input wire logic       psel,
   input wire logic       penable,
   input wire logic [7:0] paddr,
   input wire logic       pready,
   input wire logic       pslverr,
   input wire logic [7:0] outputContact,
   input wire logic       errorLamp,
   input wire logic       initDoneFlag
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_ready_onewait: assert property (psel && penable && !pready |=> pready)
      else $error("pready missing after one wait state");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_ready_inxfer: assert property (pready |-> psel && penable)
      else $error("pready outside an access phase");
   a_err_unmapped: assert property (psel && !penable && paddr > 8'h1C |=> ##1 (pslverr && pready))
      else $error("unmapped address not refused");
   a_reset_clear: assert property (disable iff (1'b0) rst |=> outputContact == 8'h00 && !errorLamp)
      else $error("outputs not cleared by reset");
   a_out_hold: assert property ($changed(outputContact) |=> $stable(outputContact) [*3])
      else $error("output latch changed within one scan");
   a_init_stays: assert property ($rose(initDoneFlag) |-> initDoneFlag [*3])
      else $error("init done did not stay high");
   a_reinit_done: assert property ($fell(initDoneFlag) && !$past(rst) |-> ##[1:300] initDoneFlag)
      else $error("re-initialisation did not complete");

   c_reinit: cover property ($fell(initDoneFlag) && !$past(rst));
   c_slverr: cover property (pslverr);
   c_out: cover property ($changed(outputContact));
   c_lamp: cover property ($rose(errorLamp));
endmodule

bind psio_scan_io psio_scan_io_properties u_props (
   .clk(clk), .rst(rst), .psel(psel), .penable(penable), .paddr(paddr), .pready(pready),
   .pslverr(pslverr), .outputContact(outputContact), .errorLamp(errorLamp), .initDoneFlag(initDoneFlag)
);
`default_nettype wire

// [psio_scan_io_tb.sv]
// Self-checking testbench of the scan I/O image engine
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin testsRun++; if ((a) !== (b)) begin errTotal++; \
   $display("Error at %0t: got %h expected %h", $time, a, b); end end
module psio_scan_io_tb;
   import psio_pkg::*;
   logic        clk, rst, psel, penable, pwrite, pready, pslverr, errorLamp, initDoneFlag, irqFire, err;
   logic [7:0]  paddr, pin, irq, outputContact, swLevel, loadOn;
   logic [31:0] pwdata, prdata, rd, cnt;
   logic [2:0]  irqChan;
   int          errTotal, testsRun, n;
   psio_word_t  prog [14];

   psio_scan_io dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .physicalInputPin(pin),
      .extInputIrq(irq), .outputContact(outputContact), .errorLamp(errorLamp), .initDoneFlag(initDoneFlag));
   psio_field_model field (.clk(clk), .swLevel(swLevel), .irqChan(irqChan), .irqFire(irqFire),
      .physicalInputPin(pin), .extInputIrq(irq), .outputContact(outputContact), .loadOn(loadOn));

   always #2 clk = ~clk;

   function automatic psio_word_t w(psio_op_e op, psio_opd_e t, logic [11:0] a);
      return {op, 2'b00, t, 12'h000, a};
   endfunction

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 20);
      if (n >= 20) errTotal++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask

   task automatic waitScans(input int k);
      int polls;
      apb(1'b0, 8'h18, 32'h0000_0000);
      cnt = rd;
      polls = 0;
      do begin apb(1'b0, 8'h18, 32'h0000_0000); polls++; end while (rd < cnt + k && polls < 200);
   endtask

   task automatic waitInit(input logic lvl);
      n = 0;
      while (initDoneFlag !== lvl && n < 500) begin @(posedge clk); n++; end
      `CHK(initDoneFlag, lvl)
   endtask

   task automatic endOfTest;
      $display("Comparisons %0d, mismatches %0d", testsRun, errTotal);
      if (errTotal == 0 && testsRun > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   initial begin
      repeat (40000) @(posedge clk);
      errTotal++;
      endOfTest;
   end

   initial begin
      clk = 0; rst = 1; psel = 0; penable = 0; pwrite = 0; paddr = 8'h00; pwdata = 32'h0000_0000;
      swLevel = 8'h00; irqChan = 3'h0; irqFire = 0; errTotal = 0; testsRun = 0;
      prog = '{w(OP_LD, OPD_X, 12'h000), w(OP_OUT, OPD_Y, 12'h000), w(OP_LDI, OPD_X, 12'h000),
               w(OP_OUT, OPD_Y, 12'h001), w(OP_LD, OPD_X, 12'h000), w(OP_OUT, OPD_Y, 12'h001),
               w(OP_LD, OPD_X, 12'h002), w(OP_OUT, OPD_M, 12'h109), w(OP_LD, OPD_X, 12'h008),
               w(OP_LD, OPD_X, 12'h006), w(OP_SET, OPD_M, 12'h110), w(OP_LD, OPD_X, 12'h007),
               w(OP_RST, OPD_M, 12'h108), w(OP_END, OPD_NONE, 12'h000)};
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      apb(1'b0, 8'h04, 32'h0000_0000); `CHK(rd, 32'h0000_0000)
      apb(1'b0, 8'h1C, 32'h0000_0000); `CHK(rd, 32'h0000_0000)
      apb(1'b0, 8'h40, 32'h0000_0000); `CHK(err, 1'b1)
      $display("Test reset values done");
      // Odd channels capture a high pin, even channels a low one
      for (int ch = 0; ch < 8; ch++) begin
         @(posedge clk);
         swLevel <= ch[0] ? (8'h01 << ch) : 8'h00; irqChan <= ch[2:0]; irqFire <= 1'b1;
         @(posedge clk);
         irqFire <= 1'b0;
      end
      swLevel <= 8'hFF;
      apb(1'b0, 8'h1C, 32'h0000_0000); `CHK(rd, 32'h0000_00AA)
      apb(1'b0, 8'h14, 32'h0000_0000); `CHK(rd, 32'h0000_0000)
      $display("Test interrupt capture done");
      swLevel <= 8'h05;
      apb(1'b1, 8'h08, 32'h0000_0000);
      for (int i = 0; i < 14; i++) apb(1'b1, 8'h0C, prog[i]);
      apb(1'b1, 8'h00, 32'h0000_0001);
      waitInit(1'b1);
      waitScans(2);
      `CHK(outputContact, 8'h03)
      `CHK(loadOn, 8'h03)
      `CHK(errorLamp, 1'b1)
      apb(1'b0, 8'h14, 32'h0000_0000); `CHK(rd, 32'h0000_0005)
      apb(1'b0, 8'h04, 32'h0000_0000); `CHK(rd[2], 1'b1)
      swLevel <= 8'h00;
      waitScans(2);
      `CHK(outputContact, 8'h00)
      `CHK(errorLamp, 1'b0)
      $display("Test scan image done");
      swLevel <= 8'h80;
      waitInit(1'b0);
      swLevel <= 8'h00;
      waitInit(1'b1);
      apb(1'b0, 8'h1C, 32'h0000_0000); `CHK(rd, 32'h0000_01AA)
      $display("Test re-initialisation done");
      swLevel <= 8'hC0;
      waitInit(1'b0);
      swLevel <= 8'h00;
      waitInit(1'b1);
      apb(1'b0, 8'h1C, 32'h0000_0000); `CHK(rd, 32'h0000_0100)
      $display("Test reboot done");
      endOfTest;
   end
endmodule
`default_nettype wire
